// ==== common/bcr_pkg.sv ====
// Constants for the board control register bank: offsets, fields, reset values, timing.
// Assumes the bus front end has already matched the board base address and hands over offsets.
package bcr_pkg;

  // Register offsets relative to the board base address
  localparam logic [15:0] SLOT_POSITION_OFS     = 16'h8008;
  localparam logic [15:0] MODULE_RESET_OFS      = 16'h800a;
  localparam logic [15:0] FIRMWARE_REVISION_OFS = 16'h800c;
  localparam logic [15:0] INTERFACE_FLASH_SEL   = 16'h800e;
  localparam logic [15:0] INTERFACE_FLASH_DATA  = 16'h8010;
  localparam logic [15:0] APPLICATION_FLASH_SEL = 16'h8012;
  localparam logic [15:0] APPLICATION_FLASH_DAT = 16'h8014;
  localparam logic [15:0] CONFIG_RELOAD_OFS     = 16'h8016;
  localparam logic [15:0] TEST_SHORT_OFS        = 16'h8018;
  localparam logic [15:0] TEST_LONG_OFS         = 16'h8020;

  // Flash channels: 0 is the bus-interface logic, 1 the application array
  localparam int          FLASH_CH = 2;
  localparam logic [15:0] FLASH_SEL_OFS  [FLASH_CH] = '{INTERFACE_FLASH_SEL, APPLICATION_FLASH_SEL};
  localparam logic [15:0] FLASH_DATA_OFS [FLASH_CH] = '{INTERFACE_FLASH_DATA, APPLICATION_FLASH_DAT};

  // Field layouts and fixed values
  localparam int          SLOT_W        = 5;
  localparam logic [4:0]  SLOT_ABSENT   = 5'h1f;
  localparam int          IMAGE_BIT     = 0;
  localparam logic        IMAGE_DEFAULT = 1'b1;
  localparam logic [7:0]  FW_MAJOR      = 8'h01;
  localparam logic [7:0]  FW_MINOR      = 8'h00;
  localparam logic [15:0] SELECT_RESET  = 16'h0000;
  localparam logic [15:0] SHORT_RESET   = 16'h0000;
  localparam logic [31:0] LONG_RESET    = 32'h0000_0000;

  // Module reset pulse width
  localparam int          CLOCK_NS        = 4;
  localparam int          RESET_PULSE_NS  = 200;
  localparam int          RESET_PULSE_CYC = (RESET_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int          RESET_CNT_W     = 8;

endpackage : bcr_pkg

// ==== rtl/bcr_board_regs.sv ====
// Board control register bank: slot position, module reset, revision, flash ports, reload, test words.
// Assumes offsets arrive already base-relative; one request per cycle, answered on the next edge.
//
// Operation
// - Slot pin levels read in bits 4..0 at 0x8008, upper bits zero.
// - Without slot pins, slot register reads fixed 0x1F.
// - A write to 0x800A outside a running pulse fires one module reset pulse.
// - Revision at 0x800C, major in 15..8, minor in 7..0.
// - 16-bit test word at 0x8018, D16 or D32, reads back last write.
// - 32-bit test word at 0x8020, D32 only, reads back last write.
// - Select 0x800E and data 0x8010 reach the interface logic flash.
// - Select 0x8012 and data 0x8014 reach the application array flash.
// - Any write to 0x8016 starts an application array reload.
// - Bit 0 of 0x8016 selects image, default 1, others reserved.
// - Offsets are base-relative; D16 and D32 cycles supported.
`timescale 1ns/1ps
module bcr_board_regs
  import bcr_pkg::*;
(
  input  wire logic                           clock,
  input  wire logic                           resetn,
  input  wire logic                           ce,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [15:0]                    reg_addr,
  input  wire logic                           reg_wide,
  input  wire logic [31:0]                    reg_wdata,
  output logic      [31:0]                    reg_rdata,
  output logic                                reg_ack,
  input  wire logic [bcr_pkg::SLOT_W-1:0]     geo_pins,
  input  wire logic                           geo_present,
  input  wire logic [bcr_pkg::FLASH_CH-1:0][15:0] flash_rdata,
  output logic      [bcr_pkg::FLASH_CH-1:0][15:0] flash_select,
  output logic      [bcr_pkg::FLASH_CH-1:0][15:0] flash_wdata,
  output logic      [bcr_pkg::FLASH_CH-1:0]   flash_wr,
  output logic      [bcr_pkg::FLASH_CH-1:0]   flash_rd,
  output logic                                module_reset,
  output logic                                cfg_reload,
  output logic                                image_select
);

  logic                       wr_ok;
  logic                       rd_ok;
  logic [15:0]                test_word_short;
  logic [31:0]                test_word_long;
  logic [FLASH_CH-1:0]        sel_hit;
  logic [FLASH_CH-1:0]        data_hit;
  logic [FLASH_CH-1:0][15:0]  chan_rdata;
  logic [15:0]                flash_mux;
  logic [31:0]                next_rdata;

  // Requests only count while the clock enable lets state move
  assign wr_ok = ce && reg_wr;
  assign rd_ok = ce && reg_rd;

  // One answer per request, one edge later, whether mapped or not
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_ack <= 1'b0;
    end else if (ce) begin
      reg_ack <= reg_wr || reg_rd;
    end
  end

  // Module reset pulse generator; the data of the write is irrelevant
  bcr_reset_pulse u_reset_pulse (
    .clock   (clock),
    .resetn  (resetn),
    .ce      (ce),
    .trigger (wr_ok && reg_addr == MODULE_RESET_OFS),
    .pulse   (module_reset)
  );

  // Short test word: a D32 write keeps only the low half
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      test_word_short <= SHORT_RESET;
    end else if (wr_ok && reg_addr == TEST_SHORT_OFS) begin
      test_word_short <= reg_wdata[15:0];
    end
  end

  // Long test word: D16 writes are ignored since half a word would tear it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      test_word_long <= LONG_RESET;
    end else if (wr_ok && reg_wide && reg_addr == TEST_LONG_OFS) begin
      test_word_long <= reg_wdata;
    end
  end

  // Reload strobe and image select; reserved bits are dropped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_reload   <= 1'b0;
      image_select <= IMAGE_DEFAULT;
    end else if (ce) begin
      cfg_reload <= reg_wr && reg_addr == CONFIG_RELOAD_OFS;
      if (reg_wr && reg_addr == CONFIG_RELOAD_OFS) begin
        image_select <= reg_wdata[IMAGE_BIT];
      end
    end
  end

  // Per-flash select register and data port strobes
  for (genvar ch = 0; ch < FLASH_CH; ch++) begin : g_flash
    assign sel_hit[ch]    = reg_addr == FLASH_SEL_OFS[ch];
    assign data_hit[ch]   = reg_addr == FLASH_DATA_OFS[ch];
    assign chan_rdata[ch] = sel_hit[ch] ? flash_select[ch] : (data_hit[ch] ? flash_rdata[ch] : 16'h0000);

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        flash_select[ch] <= SELECT_RESET;
        flash_wdata[ch]  <= 16'h0000;
        flash_wr[ch]     <= 1'b0;
        flash_rd[ch]     <= 1'b0;
      end else if (ce) begin
        flash_wr[ch] <= reg_wr && data_hit[ch];
        flash_rd[ch] <= reg_rd && data_hit[ch];
        if (reg_wr && sel_hit[ch]) begin
          flash_select[ch] <= reg_wdata[15:0];
        end
        if (reg_wr && data_hit[ch]) begin
          flash_wdata[ch] <= reg_wdata[15:0];
        end
      end
    end
  end

  // Combine the flash channels; at most one can hit
  always_comb begin
    flash_mux = 16'h0000;
    for (int i = 0; i < FLASH_CH; i++) begin
      flash_mux = flash_mux | chan_rdata[i];
    end
  end

  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      SLOT_POSITION_OFS:     next_rdata[SLOT_W-1:0] = geo_present ? geo_pins : SLOT_ABSENT;
      FIRMWARE_REVISION_OFS: next_rdata[15:0] = {FW_MAJOR, FW_MINOR};
      CONFIG_RELOAD_OFS:     next_rdata[IMAGE_BIT] = image_select;
      TEST_SHORT_OFS:        next_rdata[15:0] = test_word_short;
      TEST_LONG_OFS:         next_rdata = reg_wide ? test_word_long : 32'h0000_0000;
      default:               next_rdata[15:0] = flash_mux;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (rd_ok) begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence long_write_s;
    wr_ok && reg_wide && reg_addr == TEST_LONG_OFS;
  endsequence

  sequence long_read_s;
    rd_ok && reg_wide && reg_addr == TEST_LONG_OFS;
  endsequence

  slot_pins_a: assert property (rd_ok && reg_addr == SLOT_POSITION_OFS && geo_present
    |=> reg_rdata == {27'h0, $past(geo_pins)}) else $error("slot pins misread");

  slot_fixed_a: assert property (rd_ok && reg_addr == SLOT_POSITION_OFS && !geo_present
    |=> reg_rdata == 32'h0000_001f) else $error("slot fixed value wrong");

  reset_fires_a: assert property (wr_ok && reg_addr == MODULE_RESET_OFS && !module_reset
    |=> module_reset) else $error("module reset not fired");

  revision_read_a: assert property (rd_ok && reg_addr == FIRMWARE_REVISION_OFS
    |=> reg_rdata == {16'h0, FW_MAJOR, FW_MINOR}) else $error("revision wrong");

  short_word_a: assert property (wr_ok && reg_addr == TEST_SHORT_OFS
    ##1 (rd_ok && reg_addr == TEST_SHORT_OFS && !reg_wr)
    |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 2)}) else $error("short word lost");

  long_word_a: assert property (long_write_s ##1 (long_read_s and (!reg_wr))
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("long word lost");

  long_narrow_a: assert property (wr_ok && !reg_wide && reg_addr == TEST_LONG_OFS
    |=> $stable(test_word_long)) else $error("narrow write hit long word");

  flash_strobe_a: assert property (wr_ok && reg_addr == INTERFACE_FLASH_DATA
    |=> flash_wr[0] && !flash_wr[1] && flash_wdata[0] == $past(reg_wdata[15:0]))
    else $error("interface flash write lost");

  app_select_a: assert property (wr_ok && reg_addr == APPLICATION_FLASH_SEL
    |=> flash_select[1] == $past(reg_wdata[15:0])) else $error("application select lost");

  reload_pulse_a: assert property (wr_ok && reg_addr == CONFIG_RELOAD_OFS
    |=> cfg_reload && image_select == $past(reg_wdata[IMAGE_BIT])) else $error("reload pulse wrong");

  // Back-to-back reload writes may keep the strobe up; only a lone one must drop
  reload_single_a: assert property (ce && cfg_reload && !(reg_wr && reg_addr == CONFIG_RELOAD_OFS)
    |=> !cfg_reload) else $error("reload pulse stretched");

  answer_once_a: assert property ((wr_ok || rd_ok) |=> reg_ack) else $error("no answer");

  reserved_zero_a: assert property (rd_ok && reg_addr == CONFIG_RELOAD_OFS
    |=> reg_rdata[31:1] == 31'h0) else $error("reserved bits not zero");

endmodule : bcr_board_regs

// ==== rtl/bcr_reset_pulse.sv ====
// One-shot module reset generator: a trigger starts a fixed-width reset pulse.
// Assumes the trigger is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ps
module bcr_reset_pulse
  import bcr_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic trigger,
  output logic      pulse
);

  typedef enum logic [0:0] {
    RP_IDLE = 1'b0,
    RP_HOLD = 1'b1
  } bcr_rp_state_t;

  localparam logic [RESET_CNT_W-1:0] LAST = RESET_CNT_W'(RESET_PULSE_CYC - 1);

  bcr_rp_state_t              state;
  logic [RESET_CNT_W-1:0]     count;

  // Retrigger during the pulse is ignored so the width stays fixed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= RP_IDLE;
      count <= '0;
      pulse <= 1'b0;
    end else if (ce) begin
      case (state)
        RP_IDLE: begin
          count <= '0;
          if (trigger) begin
            state <= RP_HOLD;
            pulse <= 1'b1;
          end
        end
        RP_HOLD: begin
          if (count == LAST) begin
            state <= RP_IDLE;
            pulse <= 1'b0;
          end else begin
            count <= count + 1'b1;
          end
        end
        default: begin
          state <= RP_IDLE;
          pulse <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence rp_start_s;
    ce && trigger && state == RP_IDLE;
  endsequence

  pulse_starts_a: assert property (rp_start_s |=> pulse) else $error("reset pulse did not start");

  pulse_ends_a: assert property (state == RP_HOLD && ce && count == LAST |=> !pulse)
    else $error("reset pulse outlived its width");

endmodule : bcr_reset_pulse

// ==== tb/bcr_bus_master.sv ====
// Bus master model for the board control register bank: single D16 or D32 register cycles.
// Assumes the bank takes a one-cycle strobe and acks on the following edge.
`timescale 1ns/1ps
module bcr_bus_master (
  input  wire logic        clock,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [15:0]      reg_addr,
  output logic             reg_wide,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wide = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // One access; any write data is sent as given, whatever register it hits
  task automatic access(input logic wr, input logic [15:0] ofs, input logic wide, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ack);
    @(negedge clock);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = ofs;
    reg_wide = wide;
    reg_wdata = wd;
    @(posedge clock);
    @(negedge clock);
    ack = reg_ack;
    rd = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines flip so a stale value can never pass for a live one
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : access
endmodule : bcr_bus_master

// ==== tb/board_control_registers_bench.sv ====
// Self-checking bench for the board control register bank, random data from a fixed seed.
// Assumes the bus master model and the bank package are compiled first.
`timescale 1ns/1ps
module board_control_registers_bench;
  import bcr_pkg::*;
  logic                   clock, resetn, ce, geo_present, reg_wr, reg_rd, reg_wide, reg_ack;
  logic                   module_reset, cfg_reload, image_select, ack;
  logic [4:0]             geo_pins;
  logic [15:0]            reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, d, v, seed;
  logic [1:0][15:0]       flash_rdata, flash_select, flash_wdata;
  logic [1:0]             flash_wr, flash_rd;
  int                     n_fail, total_checks, n;

  bcr_board_regs dut (.clock(clock), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wide(reg_wide), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .geo_pins(geo_pins), .geo_present(geo_present), .flash_rdata(flash_rdata),
    .flash_select(flash_select), .flash_wdata(flash_wdata), .flash_wr(flash_wr), .flash_rd(flash_rd),
    .module_reset(module_reset), .cfg_reload(cfg_reload), .image_select(image_select));
  bcr_bus_master mst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wide(reg_wide), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] draw();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : draw

  // Slot register: pins when present, all ones otherwise
  function automatic logic [31:0] exp_slot(input logic present, input logic [4:0] pins);
    return present ? {27'h0, pins} : {27'h0, SLOT_ABSENT};
  endfunction : exp_slot

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : chk1

  task automatic wr(input logic [15:0] ofs, input logic wide, input logic [31:0] wd);
    mst.access(1'b1, ofs, wide, wd, d, ack);
    chk1("reg_ack", 1'b1, ack);
  endtask : wr

  task automatic rd(input logic [15:0] ofs, input logic wide);
    mst.access(1'b0, ofs, wide, 32'h0, d, ack);
    chk1("reg_ack", 1'b1, ack);
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the roughly 130 cycles the sequence needs
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end

  initial begin
    seed = 32'h9dc5;
    n_fail = 0;
    total_checks = 0;
    ce = 1'b1;
    resetn = 1'b0;
    geo_present = 1'b1;
    geo_pins = 5'h00;
    flash_rdata = '0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    chk1("image_select", IMAGE_DEFAULT, image_select);
    // Slot position on both board variants, D16 and D32
    for (int i = 0; i < 4; i++) begin
      geo_present = i[0];
      v = draw();
      geo_pins = v[4:0];
      rd(SLOT_POSITION_OFS, i[1]);
      chk("slot_position", exp_slot(geo_present, geo_pins), d);
    end
    rd(FIRMWARE_REVISION_OFS, 1'b1);
    chk("firmware_revision", {16'h0, FW_MAJOR, FW_MINOR}, d);
    // Test words with all-ones corner, random and zero data
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'hffff_ffff : (i == 1) ? draw() : 32'h0;
      wr(TEST_SHORT_OFS, 1'b1, v);
      rd(TEST_SHORT_OFS, i[0]);
      chk("test_word_short", {16'h0, v[15:0]}, d);
      wr(TEST_LONG_OFS, 1'b1, v);
      wr(TEST_LONG_OFS, 1'b0, ~v);
      rd(TEST_LONG_OFS, 1'b1);
      chk("test_word_long", v, d);
      rd(TEST_LONG_OFS, 1'b0);
      chk("test_word_long_d16", 32'h0, d);
    end
    // Clock enable low: a write is neither taken nor answered
    @(negedge clock);
    ce = 1'b0;
    mst.access(1'b1, TEST_SHORT_OFS, 1'b1, draw(), d, ack);
    chk1("reg_ack_frozen", 1'b0, ack);
    ce = 1'b1;
    rd(TEST_SHORT_OFS, 1'b1);
    chk("test_word_short_frozen", {16'h0, v[15:0]}, d);
    // Both flash channels: select readback, data write and data read
    for (int ch = 0; ch < FLASH_CH; ch++) begin
      v = draw();
      wr(FLASH_SEL_OFS[ch], 1'b1, v);
      chk("flash_select", {16'h0, v[15:0]}, {16'h0, flash_select[ch]});
      rd(FLASH_SEL_OFS[ch], 1'b0);
      chk("flash_select_read", {16'h0, v[15:0]}, d);
      v = draw();
      wr(FLASH_DATA_OFS[ch], 1'b0, v);
      chk1("flash_wr", 1'b1, flash_wr[ch]);
      chk("flash_wdata", {16'h0, v[15:0]}, {16'h0, flash_wdata[ch]});
      v = draw();
      flash_rdata[ch] = v[15:0];
      rd(FLASH_DATA_OFS[ch], 1'b0);
      chk1("flash_rd", 1'b1, flash_rd[ch]);
      chk("flash_data_read", {16'h0, flash_rdata[ch]}, d);
    end
    // Reload with each image bit, reserved bit 1 set and bits 31..2 random
    for (int i = 0; i < 2; i++) begin
      v = draw();
      v = {v[31:2], 1'b1, i[0]};
      wr(CONFIG_RELOAD_OFS, 1'b0, v);
      chk1("cfg_reload", 1'b1, cfg_reload);
      chk1("image_select", v[0], image_select);
      rd(CONFIG_RELOAD_OFS, 1'b0);
      chk1("cfg_reload_single", 1'b0, cfg_reload);
      chk("application_config_reload", {31'h0, v[0]}, d);
    end
    // Module reset: one pulse of the full width
    wr(MODULE_RESET_OFS, 1'b0, draw());
    n = 0;
    while (module_reset === 1'b1 && n < 100) begin
      n++;
      @(negedge clock);
    end
    chk("module_reset_cycles", RESET_PULSE_CYC, n);
    rd(MODULE_RESET_OFS, 1'b0);
    chk("module_reset_trigger", 32'h0, d);
    rd(16'h8000, 1'b1);
    chk("unmapped", 32'h0, d);
    end_sim();
  end
endmodule : board_control_registers_bench
